// ==== hw/osc_ctrl.sv ====
// Oscillator source control: clock configuration, checks, interrupts, APB slave
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module osc_ctrl #(
  parameter int unsigned VERIFY_CYC = osc_pkg::VERIFY_TIMEOUT_CYC
) (
  input  wire logic                   CLK_SYS,
  input  wire logic                   RST,
  input  wire osc_pkg::osc_apb_req_s  APB_REQ,
  output osc_pkg::osc_apb_rsp_s       APB_RSP,
  input  wire logic                   MAIN_OSC_IN,
  input  wire logic                   INT_OSC_IN,
  output osc_pkg::osc_cfg_s           CFG,
  output logic                        MAIN_OSC_EN,
  output logic                        INT_OSC_EN,
  output osc_pkg::osc_pll_mode_e      PLL_MODE,
  output logic                        IRQ
);
  import osc_pkg::*;

  // Controller state; one next-state process and one register stage, the two activity checks keep their own
  typedef struct packed {
    osc_cfg_s          cfg;
    logic [IRQ_W-1:0]  istat;
    logic [IRQ_W-1:0]  imask;
    osc_pll_mode_e     pll_mode;
    logic [DATA_W-1:0] prdata;
    logic              pslverr;
    logic              irq;
    logic              main_en;
    logic              int_en;
  } osc_top_state_s;

  localparam osc_top_state_s ST_RST = '{
    cfg:      CFG_RST,
    istat:    '0,
    imask:    '0,
    pll_mode: OSC_PLL_POWER_DOWN,
    prdata:   '0,
    pslverr:  1'b0,
    irq:      1'b0,
    main_en:  1'b1,
    int_en:   1'b1
  };

  osc_top_state_s   s_r;
  osc_top_state_s   s_nxt;
  logic             main_alive;
  logic             int_alive;
  logic             main_fail;
  logic             int_fail;
  logic [IRQ_W-1:0] fail_evt;
  logic             setup_ph;
  logic             wr_acc;
  logic [DATA_W-1:0] wr_word;
  logic [IRQ_W-1:0]  w1c_bits;
  logic [IRQ_W-1:0]  ver_en;
  logic [DATA_W-1:0] ostat_word;

  // Byte-lane merge of a write into the current word
  function automatic logic [DATA_W-1:0] strb_merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] w;
    w = old_w;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        w[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return w;
  endfunction : strb_merge

  // Register image of the configuration; unimplemented bits read as zero
  function automatic logic [DATA_W-1:0] cfg_to_word(input osc_cfg_s c);
    logic [DATA_W-1:0] w;
    w                    = '0;
    w[PLL_POWER_DOWN_BIT]         = c.pll_power_down;
    w[OEN_BIT]           = c.pll_output_driver_ctrl;
    w[CRYSTAL_FREQ_CODE_MSB:CRYSTAL_FREQ_CODE_LSB] = c.crystal_freq_code;
    w[SRC_MSB:SRC_LSB]   = c.osc_source_select;
    w[IVER_BIT]          = c.int_osc_verify_en;
    w[MVER_BIT]          = c.main_osc_verify_en;
    w[IDIS_BIT]          = c.int_osc_disable;
    w[MDIS_BIT]          = c.main_osc_disable;
    return w;
  endfunction : cfg_to_word

  // Applies a merged write word; refused field codes keep the old value
  function automatic osc_cfg_s cfg_write(
    input osc_cfg_s          old_c,
    input logic [DATA_W-1:0] w
  );
    osc_cfg_s c;
    c = old_c;
    c.pll_power_down         = w[PLL_POWER_DOWN_BIT];
    c.pll_output_driver_ctrl = w[OEN_BIT];
    // Reserved codes would leave the PLL translation undefined, so they are dropped
    if (w[CRYSTAL_FREQ_CODE_MSB:CRYSTAL_FREQ_CODE_LSB] >= CRYSTAL_FREQ_CODE_MIN_OK) begin
      c.crystal_freq_code = w[CRYSTAL_FREQ_CODE_MSB:CRYSTAL_FREQ_CODE_LSB];
    end
    if (w[SRC_MSB:SRC_LSB] != SRC_RSVD) begin
      c.osc_source_select = w[SRC_MSB:SRC_LSB];
    end
    c.int_osc_verify_en  = w[IVER_BIT];
    c.main_osc_verify_en = w[MVER_BIT];
    c.int_osc_disable    = w[IDIS_BIT];
    c.main_osc_disable   = w[MDIS_BIT];
    return c;
  endfunction : cfg_write

  // Power-down dominates; with only the output driver off the PLL runs unseen
  function automatic osc_pll_mode_e pll_mode_of(input osc_cfg_s c);
    osc_pll_mode_e m;
    if (c.pll_power_down) begin
      m = OSC_PLL_POWER_DOWN;
    end else if (!c.pll_output_driver_ctrl) begin
      m = OSC_PLL_NORMAL;
    end else begin
      m = OSC_PLL_OUT_OFF;
    end
    return m;
  endfunction : pll_mode_of

  // Unaligned or unmapped addresses answer with an error and are otherwise ignored
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic h;
    case (a)
      OFF_CFG:   h = 1'b1;
      OFF_ISTAT: h = 1'b1;
      OFF_IMASK: h = 1'b1;
      OFF_OSTAT: h = 1'b1;
      default:   h = 1'b0;
    endcase
    return h;
  endfunction : addr_hit

  function automatic logic [DATA_W-1:0] osc_status_word(
    input logic          m_alive,
    input logic          i_alive,
    input osc_pll_mode_e mode
  );
    logic [DATA_W-1:0] w;
    w                    = '0;
    w[ALIVE_MAIN]        = m_alive;
    w[ALIVE_INT]         = i_alive;
    w[MODE_MSB:MODE_LSB] = mode;
    return w;
  endfunction : osc_status_word

  // Read mux over the four registers; unknown offsets read as zero
  function automatic logic [DATA_W-1:0] read_word(
    input logic [ADDR_W-1:0] a,
    input osc_cfg_s          c,
    input logic [IRQ_W-1:0]  stat,
    input logic [IRQ_W-1:0]  mask,
    input logic [DATA_W-1:0] ostat
  );
    logic [DATA_W-1:0] w;
    case (a)
      OFF_CFG:   w = cfg_to_word(c);
      OFF_ISTAT: w = DATA_W'(stat);
      OFF_IMASK: w = DATA_W'(mask);
      OFF_OSTAT: w = ostat;
      default:   w = '0;
    endcase
    return w;
  endfunction : read_word

  // Mask write honours byte lanes like the configuration does
  function automatic logic [IRQ_W-1:0] mask_write(
    input logic [IRQ_W-1:0]  old_m,
    input logic [DATA_W-1:0] w,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] merged;
    merged = strb_merge(DATA_W'(old_m), w, strb);
    return merged[IRQ_W-1:0];
  endfunction : mask_write

  // Sticky status: clear by one, drop bits whose check is off, then set; the set
  // is applied last, so a failure in the cycle of a clear or a disable is kept
  function automatic logic [IRQ_W-1:0] istat_next(
    input logic [IRQ_W-1:0] stat,
    input logic [IRQ_W-1:0] w1c,
    input logic [IRQ_W-1:0] en,
    input logic [IRQ_W-1:0] evt
  );
    logic [IRQ_W-1:0] n;
    n = stat & ~w1c;
    n = n & en;
    n = n | evt;
    return n;
  endfunction : istat_next

  // One activity check per oscillator; a stopped oscillator trips only its own flag

  osc_verify #(
    .TIMEOUT_CYC (VERIFY_CYC)
  ) u_main_verify (
    .clk     (CLK_SYS),
    .rst     (RST),
    .osc_pin (MAIN_OSC_IN),
    .enable  (s_r.cfg.main_osc_verify_en),
    .alive   (main_alive),
    .fail    (main_fail)
  );

  osc_verify #(
    .TIMEOUT_CYC (VERIFY_CYC)
  ) u_int_verify (
    .clk     (CLK_SYS),
    .rst     (RST),
    .osc_pin (INT_OSC_IN),
    .enable  (s_r.cfg.int_osc_verify_en),
    .alive   (int_alive),
    .fail    (int_fail)
  );

  always_comb begin
    fail_evt           = '0;
    fail_evt[IRQ_MAIN] = main_fail;
    fail_evt[IRQ_INT]  = int_fail;
    ver_en             = '0;
    ver_en[IRQ_MAIN]   = s_r.cfg.main_osc_verify_en;
    ver_en[IRQ_INT]    = s_r.cfg.int_osc_verify_en;
  end

  // APB phases; pready is tied high, so every access phase lasts one cycle
  assign setup_ph   = APB_REQ.psel && !APB_REQ.penable;
  assign wr_acc     = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  assign ostat_word = osc_status_word(main_alive, int_alive, s_r.pll_mode);

  always_comb begin
    s_nxt    = s_r;
    wr_word  = '0;
    w1c_bits = '0;

    // Read data and error are captured in setup so the access phase needs no wait
    if (setup_ph) begin
      s_nxt.pslverr = !addr_hit(APB_REQ.paddr);
      s_nxt.prdata  = '0;
      if (!APB_REQ.pwrite) begin
        s_nxt.prdata = read_word(APB_REQ.paddr, s_r.cfg, s_r.istat, s_r.imask, ostat_word);
      end
    end

    if (wr_acc) begin
      case (APB_REQ.paddr)
        OFF_CFG: begin
          wr_word   = strb_merge(cfg_to_word(s_r.cfg), APB_REQ.pwdata, APB_REQ.pstrb);
          s_nxt.cfg = cfg_write(s_r.cfg, wr_word);
        end
        OFF_ISTAT: begin
          // Only lane 0 carries status bits
          if (APB_REQ.pstrb[0]) begin
            w1c_bits = APB_REQ.pwdata[IRQ_W-1:0];
          end
        end
        OFF_IMASK: begin
          s_nxt.imask = mask_write(s_r.imask, APB_REQ.pwdata, APB_REQ.pstrb);
        end
        default: begin
          wr_word = '0;
        end
      endcase
    end

    // A disabled check drops its flag; a failure in the same cycle still wins
    s_nxt.istat = istat_next(s_r.istat, w1c_bits, ver_en, fail_evt);

    s_nxt.pll_mode = pll_mode_of(s_nxt.cfg);
    s_nxt.main_en  = !s_nxt.cfg.main_osc_disable;
    s_nxt.int_en   = !s_nxt.cfg.int_osc_disable;
    s_nxt.irq      = |(s_nxt.istat & s_nxt.imask);
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign APB_RSP.pready  = 1'b1;
  assign APB_RSP.prdata  = s_r.prdata;
  assign APB_RSP.pslverr = s_r.pslverr;

  // Outputs come straight from the state register
  assign CFG         = s_r.cfg;
  assign MAIN_OSC_EN = s_r.main_en;
  assign INT_OSC_EN  = s_r.int_en;
  assign PLL_MODE    = s_r.pll_mode;
  assign IRQ         = s_r.irq;

endmodule : osc_ctrl

// ==== hw/osc_pkg.sv ====
// Constants, types and register layout of the oscillator source control block
// Notes on behaviour
// - Four-bit crystal code at bits 9:6, read/write, resets to 0xb.
// - Crystal codes 0-3 are reserved; 4-15 are fixed crystals, 0xb is 6 MHz.
// - Source select at bits 5:4, reset 0: main, internal, internal/4, reserved.
// - Bit 3 enables internal oscillator check; failure raises an interrupt.
// - Bit 2 enables main oscillator check; failure raises an interrupt.
// - Bit 1 clear keeps the internal oscillator running; set stops it.
// - Bit 0 clear keeps the main oscillator running; set stops it.
// - PLL powered down while power-down is 1; normal when both controls are 0.
// - PLL power-down control resets to one.
package osc_pkg;

  localparam int unsigned DATA_W   = 32;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned STRB_W   = DATA_W / 8;
  localparam int unsigned IRQ_W    = 2;

  localparam logic [ADDR_W-1:0] OFF_CFG   = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_ISTAT = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_IMASK = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_OSTAT = 12'h00c;

  localparam int unsigned CRYSTAL_FREQ_CODE_LSB  = 6;
  localparam int unsigned CRYSTAL_FREQ_CODE_MSB  = 9;
  localparam int unsigned SRC_LSB   = 4;
  localparam int unsigned SRC_MSB   = 5;
  localparam int unsigned IVER_BIT  = 3;
  localparam int unsigned MVER_BIT  = 2;
  localparam int unsigned IDIS_BIT  = 1;
  localparam int unsigned MDIS_BIT  = 0;
  localparam int unsigned OEN_BIT   = 12;
  localparam int unsigned PLL_POWER_DOWN_BIT = 13;

  localparam int unsigned IRQ_MAIN  = 0;
  localparam int unsigned IRQ_INT   = 1;
  localparam int unsigned ALIVE_MAIN = 0;
  localparam int unsigned ALIVE_INT  = 1;
  localparam int unsigned MODE_LSB   = 2;
  localparam int unsigned MODE_MSB   = 3;

  localparam logic [3:0] CRYSTAL_FREQ_CODE_RST      = 4'hb;
  localparam logic [3:0] CRYSTAL_FREQ_CODE_MIN_OK   = 4'h4;
  localparam logic [1:0] SRC_MAIN      = 2'h0;
  localparam logic [1:0] SRC_INT       = 2'h1;
  localparam logic [1:0] SRC_INT_DIV4  = 2'h2;
  localparam logic [1:0] SRC_RSVD      = 2'h3;

  localparam int unsigned CLK_PERIOD_NS      = 50;
  localparam int unsigned VERIFY_TIMEOUT_NS  = 1000;
  localparam int unsigned VERIFY_TIMEOUT_CYC =
    (VERIFY_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    OSC_PLL_POWER_DOWN,
    OSC_PLL_NORMAL,
    OSC_PLL_OUT_OFF
  } osc_pll_mode_e;

  typedef struct packed {
    logic       pll_power_down;
    logic       pll_output_driver_ctrl;
    logic [3:0] crystal_freq_code;
    logic [1:0] osc_source_select;
    logic       int_osc_verify_en;
    logic       main_osc_verify_en;
    logic       int_osc_disable;
    logic       main_osc_disable;
  } osc_cfg_s;

  localparam osc_cfg_s CFG_RST = '{
    pll_power_down:         1'b1,
    pll_output_driver_ctrl: 1'b1,
    crystal_freq_code:      CRYSTAL_FREQ_CODE_RST,
    osc_source_select:      SRC_MAIN,
    int_osc_verify_en:      1'b0,
    main_osc_verify_en:     1'b0,
    int_osc_disable:        1'b0,
    main_osc_disable:       1'b0
  };

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [STRB_W-1:0] pstrb;
  } osc_apb_req_s;

  typedef struct packed {
    logic              pready;
    logic [DATA_W-1:0] prdata;
    logic              pslverr;
  } osc_apb_rsp_s;

endpackage : osc_pkg

// ==== hw/osc_verify.sv ====
// Oscillator activity check: synchronises one oscillator pin and times its edges
`timescale 1ns/1ns
module osc_verify #(
  parameter int unsigned TIMEOUT_CYC = 20
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic osc_pin,
  input  wire logic enable,
  output logic      alive,
  output logic      fail
);
  import osc_pkg::*;

  localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(TIMEOUT_CYC - 1);
  localparam logic [CW-1:0] CNT_TOP  = CW'(TIMEOUT_CYC);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);

  typedef struct packed {
    logic [2:0]    sync;
    logic          level;
    logic [CW-1:0] cnt;
    logic          alive;
    logic          fail;
  } osc_ver_state_s;

  localparam osc_ver_state_s ST_RST = '0;

  osc_ver_state_s s_r;
  osc_ver_state_s s_nxt;
  logic           edge_seen;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.sync = {s_r.sync[1:0], osc_pin};
    s_nxt.fail = 1'b0;
    // Only the second and third stages are compared; the first may be metastable
    edge_seen  = (s_r.sync[1] == s_r.sync[2]) && (s_r.sync[2] != s_r.level);
    if (edge_seen) begin
      s_nxt.level = s_r.sync[2];
    end
    if (!enable) begin
      s_nxt.cnt   = '0;
      s_nxt.alive = 1'b0;
    end else if (edge_seen) begin
      s_nxt.cnt   = '0;
      s_nxt.alive = 1'b1;
    end else if (s_r.cnt != CNT_TOP) begin
      s_nxt.cnt = s_r.cnt + CNT_ONE;
      if (s_r.cnt == CNT_LAST) begin
        // One pulse per stall; counter then parks until an edge returns
        s_nxt.fail  = 1'b1;
        s_nxt.alive = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign alive = s_r.alive;
  assign fail  = s_r.fail;

endmodule : osc_verify

// ==== dv/osc_ctrl_props.sv ====
// Port checker for the oscillator source control block
`timescale 1ns/1ns
module osc_ctrl_props #(
  parameter int unsigned VERIFY_CYC = 20
) (
  input wire logic                   CLK_SYS,
  input wire logic                   RST,
  input wire osc_pkg::osc_apb_req_s  APB_REQ,
  input wire osc_pkg::osc_apb_rsp_s  APB_RSP,
  input wire logic                   MAIN_OSC_IN,
  input wire logic                   INT_OSC_IN,
  input wire osc_pkg::osc_cfg_s      CFG,
  input wire logic                   MAIN_OSC_EN,
  input wire logic                   INT_OSC_EN,
  input wire osc_pkg::osc_pll_mode_e PLL_MODE,
  input wire logic                   IRQ
);
  import osc_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  wire logic wr_acc = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  wire logic no_ver = !CFG.main_osc_verify_en && !CFG.int_osc_verify_en;

  a_main_en_map: assert property (MAIN_OSC_EN == !CFG.main_osc_disable)
    else $error("main oscillator enable does not follow its disable bit");
  a_int_en_map: assert property (INT_OSC_EN == !CFG.int_osc_disable)
    else $error("internal oscillator enable does not follow its disable bit");
  a_pll_down: assert property (CFG.pll_power_down |-> PLL_MODE == OSC_PLL_POWER_DOWN)
    else $error("pll not powered down while power-down is set");
  a_pll_normal: assert property (!CFG.pll_power_down && !CFG.pll_output_driver_ctrl
    |-> PLL_MODE == OSC_PLL_NORMAL)
    else $error("pll not normal with both controls clear");
  a_crystal_freq_code_legal: assert property (CFG.crystal_freq_code >= CRYSTAL_FREQ_CODE_MIN_OK)
    else $error("crystal code holds a reserved value");
  a_src_legal: assert property (CFG.osc_source_select != SRC_RSVD)
    else $error("source select holds the reserved value");
  a_cfg_hold: assert property (!wr_acc |=> $stable(CFG))
    else $error("configuration changed without a write");
  a_irq_quiet: assert property (no_ver [*3] |-> !IRQ)
    else $error("interrupt high with both checks disabled");
  a_reset_cfg: assert property ($fell(RST) |-> CFG == CFG_RST)
    else $error("configuration not at reset value after reset");

  c_irq: cover property ($rose(IRQ));
  c_normal: cover property (PLL_MODE == OSC_PLL_NORMAL);
  c_main_off: cover property ($fell(MAIN_OSC_EN));
endmodule : osc_ctrl_props

// ==== dv/tb_top.sv ====
// Self-checking bench for the oscillator source control block
`timescale 1ns/1ns
module tb_top;
  import osc_pkg::*;
  localparam int unsigned VCYC = 8;
  typedef struct packed {
    logic [31:0]   w;
    logic [31:0]   e;
    osc_pll_mode_e m;
    logic [1:0]    en;
  } osc_row_s;
  localparam osc_row_s ROWS [5] = '{
    '{32'h0000_0000, 32'h0000_02c0, OSC_PLL_NORMAL, 2'b11},
    '{32'h0000_1112, 32'h0000_1112, OSC_PLL_OUT_OFF, 2'b10},
    '{32'hffff_ffff, 32'h0000_33df, OSC_PLL_POWER_DOWN, 2'b00},
    '{32'h0000_20e1, 32'h0000_23e1, OSC_PLL_POWER_DOWN, 2'b01},
    '{32'h0000_0e20, 32'h0000_0220, OSC_PLL_NORMAL, 2'b11}};
  logic          CLK_SYS, RST, MAIN_OSC_IN, INT_OSC_IN, run_m, run_i;
  logic          men, ien, irq, err;
  logic [1:0]    ph;
  logic [31:0]   rd;
  osc_apb_req_s  req;
  osc_apb_rsp_s  rsp;
  osc_cfg_s      cfg;
  osc_pll_mode_e mode;
  int            mismatches, checked;

  osc_ctrl #(.VERIFY_CYC(VCYC)) DUT (.CLK_SYS(CLK_SYS), .RST(RST), .APB_REQ(req),
    .APB_RSP(rsp), .MAIN_OSC_IN(MAIN_OSC_IN), .INT_OSC_IN(INT_OSC_IN), .CFG(cfg),
    .MAIN_OSC_EN(men), .INT_OSC_EN(ien), .PLL_MODE(mode), .IRQ(irq));

  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end
  // Slow toggles so the three-flop synchroniser never aliases
  always @(posedge CLK_SYS) begin
    if (RST) begin
      ph <= 2'h0;
      MAIN_OSC_IN <= 1'b0;
      INT_OSC_IN <= 1'b0;
    end else begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (ph == 2'h2 && run_m) MAIN_OSC_IN <= ~MAIN_OSC_IN;
      if (ph == 2'h2 && run_i) INT_OSC_IN <= ~INT_OSC_IN;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    req.pstrb <= s;
    @(posedge CLK_SYS);
    req.penable <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      finish_test();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge CLK_SYS);
  endtask : apb
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 60) begin
      @(posedge CLK_SYS);
      n++;
    end
    if (n >= 60) begin
      mismatches++;
      finish_test();
    end
  endtask : wait_irq

  initial begin
    repeat (20000) @(posedge CLK_SYS);
    mismatches++;
    finish_test();
  end

  initial begin
    RST = 1'b1;
    req = '0;
    run_m = 1'b0;
    run_i = 1'b0;
    repeat (16) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    chk("cfg port", {20'h0, cfg}, {20'h0, CFG_RST});
    chk("mode", {30'h0, mode}, {30'h0, OSC_PLL_POWER_DOWN});
    apb(1'b0, OFF_CFG, 32'h0);
    chk("cfg reset", rd, 32'h0000_32c0);
    foreach (ROWS[i]) begin
      apb(1'b1, OFF_CFG, ROWS[i].w);
      apb(1'b0, OFF_CFG, 32'h0);
      chk("cfg", rd, ROWS[i].e);
      chk("mode", {30'h0, mode}, {30'h0, ROWS[i].m});
      chk("osc en", {30'h0, men, ien}, {30'h0, ROWS[i].en});
    end
    // Reserved codes must leave the previous code, 8, in place
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, OFF_CFG, {22'h0, c[3:0], 6'h0});
      apb(1'b0, OFF_CFG, 32'h0);
      chk("crystal_freq_code", {28'h0, rd[9:6]}, (c < 4) ? 32'h8 : 32'(c));
    end
    // Lane 0 only: upper lanes keep their bits, reserved source code is refused
    apb(1'b1, OFF_CFG, 32'hffff_ff31, 4'h1);
    apb(1'b0, OFF_CFG, 32'h0);
    chk("cfg lane0", rd, 32'h0000_0301);
    chk("en lane0", {30'h0, men, ien}, 32'h1);
    run_m <= 1'b1;
    run_i <= 1'b1;
    apb(1'b1, OFF_IMASK, 32'h3);
    apb(1'b1, OFF_CFG, 32'h0000_02cc);
    repeat (40) @(posedge CLK_SYS);
    apb(1'b0, OFF_ISTAT, 32'h0);
    chk("istat live", rd, 32'h0);
    run_m <= 1'b0;
    wait_irq();
    repeat (20) @(posedge CLK_SYS);
    apb(1'b0, OFF_ISTAT, 32'h0);
    chk("istat main", rd, 32'h1);
    chk("irq main", {31'h0, irq}, 32'h1);
    apb(1'b0, OFF_OSTAT, 32'h0);
    chk("ostat", {28'h0, rd[3:0]}, {28'h0, 2'(OSC_PLL_NORMAL), 2'b10});
    apb(1'b1, OFF_ISTAT, 32'h1);
    apb(1'b0, OFF_ISTAT, 32'h0);
    chk("istat w1c", rd, 32'h0);
    chk("irq w1c", {31'h0, irq}, 32'h0);
    apb(1'b1, OFF_IMASK, 32'h0);
    run_i <= 1'b0;
    repeat (40) @(posedge CLK_SYS);
    apb(1'b0, OFF_ISTAT, 32'h0);
    chk("istat int", rd, 32'h2);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, OFF_IMASK, 32'h2);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    apb(1'b1, OFF_CFG, 32'h0000_02c4);
    apb(1'b0, OFF_ISTAT, 32'h0);
    chk("istat off", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    RST <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    chk("cfg rerst", {20'h0, cfg}, {20'h0, CFG_RST});
    chk("mode rerst", {30'h0, mode}, {30'h0, OSC_PLL_POWER_DOWN});
    chk("en rerst", {30'h0, men, ien}, 32'h3);
    chk("irq rerst", {31'h0, irq}, 32'h0);
    apb(1'b0, OFF_CFG, 32'h0);
    chk("cfg reread", rd, 32'h0000_32c0);
    apb(1'b0, OFF_ISTAT, 32'h0);
    chk("istat rerst", rd, 32'h0);
    finish_test();
  end
endmodule : tb_top

bind osc_ctrl osc_ctrl_props #(.VERIFY_CYC(VERIFY_CYC)) u_props (.CLK_SYS(CLK_SYS),
  .RST(RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .MAIN_OSC_IN(MAIN_OSC_IN),
  .INT_OSC_IN(INT_OSC_IN), .CFG(CFG), .MAIN_OSC_EN(MAIN_OSC_EN),
  .INT_OSC_EN(INT_OSC_EN), .PLL_MODE(PLL_MODE), .IRQ(IRQ));
